// ==== verilog/rx_packet_perf_monitor.sv ====
// Receive performance monitor with header check status and APB registers
//
// What this block does
// - Count size-violation packets in 24 bits
// - Size-violation bytes go to aborted count
// - Size count readable as three LSB-first bytes
// - Count bytes of non-aborted stored packets
// - Count bytes of aborted stored packets separately
// - Byte counts readable as four LSB-first bytes
// - Dropped bytes may be included in counts
// - Update rising edge snapshots and restarts counters
// - Update bit 0 only; other bits zero
// - Done set on snapshot, cleared by zero
// - Latch bit 3 on SAPI high mismatch
// - Latch bit 2 on SAPI low mismatch
// - Latch bit 1 on control mismatch
// - Latch bit 0 on address mismatch
// - Mismatch bits hold until status read
// - Per-bit interrupt enables, reset to zero
// - Eight-bit read/write low watermark, reset zero
// - Watermark scaled by 32 times 2048 bytes
//
// Chosen here: the APB register port.
`include "rx_perf_defines.svh"
`default_nettype none
module rx_packet_perf_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire rx_perf_pkg::rx_pkt_t pkt_in,
    input wire rx_perf_pkg::rx_hdr_t hdr_in,
    output logic [23:0] txq_low_wm_bytes_out,
    output logic irq_out
);

    // Register value held in the low byte of a bus word
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h000000, b};
    endfunction : byte_word

    // Bytes a packet adds to one of the byte counters
    function automatic logic [31:0] pkt_bytes(input rx_perf_pkg::rx_pkt_t p, input logic take);
        pkt_bytes = (p.valid && take) ? {16'h0000, p.len} : 32'h00000000;
    endfunction : pkt_bytes

    // Bus slave state
    rx_perf_pkg::bus_state_t bus_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [9:0] idx;
    logic bus_done;
    logic wr_done;
    logic rd_done;
    logic idx_ok;
    logic [31:0] rd_data;

    // Software registers
    logic upd_req_q;
    logic upd_prev_q;
    logic upd_done_q;
    logic [3:0] hdr_stat_q;
    logic [3:0] hdr_ien_q;
    logic [7:0] wm_q;
    logic [23:0] wm_bytes_q;
    logic [7:0] exp_sapi_h_q;
    logic [7:0] exp_sapi_l_q;
    logic [7:0] exp_ctrl_q;
    logic [7:0] exp_addr_q;
    logic [1:0] evt_stat_q;
    logic [1:0] evt_ien_q;
    logic irq_q;

    // Live and readable counters
    logic [23:0] sv_live_q;
    logic [31:0] good_live_q;
    logic [31:0] abt_live_q;
    logic [23:0] sv_shadow_q;
    logic [31:0] good_shadow_q;
    logic [31:0] abt_shadow_q;

    logic snap;
    logic sv_inc;
    logic [31:0] good_add;
    logic [31:0] abt_add;
    logic [3:0] hdr_miss;

    // Index decode; access completes on the second access cycle
    assign idx = paddr_in[11:2];
    assign bus_done = psel_in && penable_in && pready_q;
    assign wr_done = bus_done && pwrite_in;
    assign rd_done = bus_done && !pwrite_in;

    // Read multiplexer; narrow registers read as zero above their width
    always_comb begin
        idx_ok = 1'b1;
        rd_data = 32'h00000000;
        case (idx)
            `IDX_SV_CNT0: rd_data = byte_word(sv_shadow_q[7:0]);
            `IDX_SV_CNT1: rd_data = byte_word(sv_shadow_q[15:8]);
            `IDX_SV_CNT2: rd_data = byte_word(sv_shadow_q[23:16]);
            `IDX_GOOD_CNT0: rd_data = byte_word(good_shadow_q[7:0]);
            `IDX_GOOD_CNT1: rd_data = byte_word(good_shadow_q[15:8]);
            `IDX_GOOD_CNT2: rd_data = byte_word(good_shadow_q[23:16]);
            `IDX_GOOD_CNT3: rd_data = byte_word(good_shadow_q[31:24]);
            `IDX_ABT_CNT0: rd_data = byte_word(abt_shadow_q[7:0]);
            `IDX_ABT_CNT1: rd_data = byte_word(abt_shadow_q[15:8]);
            `IDX_ABT_CNT2: rd_data = byte_word(abt_shadow_q[23:16]);
            `IDX_ABT_CNT3: rd_data = byte_word(abt_shadow_q[31:24]);
            `IDX_UPD_CTRL: rd_data = byte_word({7'h00, upd_req_q});
            `IDX_UPD_DONE: rd_data = byte_word({7'h00, upd_done_q});
            `IDX_HDR_STAT: rd_data = byte_word({4'h0, hdr_stat_q});
            `IDX_HDR_IEN: rd_data = byte_word({4'h0, hdr_ien_q});
            `IDX_TXQ_LOW_WM: rd_data = byte_word(wm_q);
            `IDX_EXP_SAPI_H: rd_data = byte_word(exp_sapi_h_q);
            `IDX_EXP_SAPI_L: rd_data = byte_word(exp_sapi_l_q);
            `IDX_EXP_CTRL: rd_data = byte_word(exp_ctrl_q);
            `IDX_EXP_ADDR: rd_data = byte_word(exp_addr_q);
            `IDX_EVT_STAT: rd_data = byte_word({6'h00, evt_stat_q});
            `IDX_EVT_CLR: rd_data = 32'h00000000;
            `IDX_EVT_IEN: rd_data = byte_word({6'h00, evt_ien_q});
            default: idx_ok = 1'b0;
        endcase
    end

    // Bus phase tracking: one wait state, then pready with data
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bus_q <= rx_perf_pkg::BUS_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            case (bus_q)
                rx_perf_pkg::BUS_IDLE: begin
                    if (psel_in && penable_in) begin
                        bus_q <= rx_perf_pkg::BUS_RESP;
                        pready_q <= 1'b1;
                        pslverr_q <= !idx_ok || (paddr_in[1:0] != 2'b00);
                        prdata_q <= pwrite_in ? 32'h00000000 : rd_data;
                    end
                end
                rx_perf_pkg::BUS_RESP: begin
                    bus_q <= rx_perf_pkg::BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    prdata_q <= 32'h00000000;
                end
                default: begin
                    bus_q <= rx_perf_pkg::BUS_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    prdata_q <= 32'h00000000;
                end
            endcase
        end
    end

    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;

    // Writable configuration registers
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            upd_req_q <= 1'b0;
            hdr_ien_q <= 4'h0;
            wm_q <= `RST_BYTE;
            exp_sapi_h_q <= `RST_EXP_BYTE;
            exp_sapi_l_q <= `RST_EXP_BYTE;
            exp_ctrl_q <= `RST_EXP_BYTE;
            exp_addr_q <= `RST_EXP_BYTE;
            evt_ien_q <= 2'b00;
        end else if (wr_done && idx_ok) begin
            case (idx)
                `IDX_UPD_CTRL: upd_req_q <= pwdata_in[`UPD_REQ_BIT];
                `IDX_HDR_IEN: hdr_ien_q <= pwdata_in[3:0];
                `IDX_TXQ_LOW_WM: wm_q <= pwdata_in[7:0];
                `IDX_EXP_SAPI_H: exp_sapi_h_q <= pwdata_in[7:0];
                `IDX_EXP_SAPI_L: exp_sapi_l_q <= pwdata_in[7:0];
                `IDX_EXP_CTRL: exp_ctrl_q <= pwdata_in[7:0];
                `IDX_EXP_ADDR: exp_addr_q <= pwdata_in[7:0];
                `IDX_EVT_IEN: evt_ien_q <= pwdata_in[1:0];
                default: upd_req_q <= upd_req_q;
            endcase
        end
    end

    // Watermark byte position: value times 32 * 2048
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wm_bytes_q <= 24'h000000;
        end else begin
            wm_bytes_q <= {wm_q, 16'h0000};
        end
    end
    assign txq_low_wm_bytes_out = wm_bytes_q;

    // Snapshot request on a rising edge of the update bit
    assign snap = upd_req_q && !upd_prev_q;
    assign sv_inc = pkt_in.valid && pkt_in.size_viol;
    assign good_add = pkt_bytes(pkt_in, !pkt_in.abort && !pkt_in.size_viol);
    assign abt_add = pkt_bytes(pkt_in, pkt_in.abort || pkt_in.size_viol);

    // Update edge detector and completion flag
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            upd_prev_q <= 1'b0;
            upd_done_q <= 1'b0;
        end else begin
            upd_prev_q <= upd_req_q;
            if (snap) begin
                upd_done_q <= 1'b1;
            end else if (!upd_req_q) begin
                upd_done_q <= 1'b0;
            end
        end
    end

    // Live counters; a packet ending in the snapshot cycle starts the new period
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sv_live_q <= 24'h000000;
            good_live_q <= 32'h00000000;
            abt_live_q <= 32'h00000000;
        end else if (snap) begin
            sv_live_q <= {23'h000000, sv_inc};
            good_live_q <= good_add;
            abt_live_q <= abt_add;
        end else begin
            sv_live_q <= sv_live_q + {23'h000000, sv_inc};
            good_live_q <= good_live_q + good_add;
            abt_live_q <= abt_live_q + abt_add;
        end
    end

    // Readable copies taken at the snapshot
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sv_shadow_q <= 24'h000000;
            good_shadow_q <= 32'h00000000;
            abt_shadow_q <= 32'h00000000;
        end else if (snap) begin
            sv_shadow_q <= sv_live_q;
            good_shadow_q <= good_live_q;
            abt_shadow_q <= abt_live_q;
        end
    end

    // Header octet compare against expected values
    always_comb begin
        hdr_miss = 4'h0;
        hdr_miss[`HDR_SAPI_H_BIT] = hdr_in.valid && (hdr_in.sapi_h != exp_sapi_h_q);
        hdr_miss[`HDR_SAPI_L_BIT] = hdr_in.valid && (hdr_in.sapi_l != exp_sapi_l_q);
        hdr_miss[`HDR_CTRL_BIT] = hdr_in.valid && (hdr_in.ctrl != exp_ctrl_q);
        hdr_miss[`HDR_ADDR_BIT] = hdr_in.valid && (hdr_in.addr != exp_addr_q);
    end

    // Latched mismatch bits; a status read clears only the bits it returned, so a
    // mismatch that lands between data capture and the completing edge is not lost
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            hdr_stat_q <= 4'h0;
        end else if (rd_done && idx == `IDX_HDR_STAT) begin
            hdr_stat_q <= (hdr_stat_q & ~prdata_q[3:0]) | hdr_miss;
        end else begin
            hdr_stat_q <= hdr_stat_q | hdr_miss;
        end
    end

    // Block event status, cleared by writing ones to the clear register
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            evt_stat_q <= 2'b00;
        end else begin
            evt_stat_q <= (evt_stat_q & ~((wr_done && idx == `IDX_EVT_CLR) ? pwdata_in[1:0] : 2'b00))
                | {|hdr_miss, snap};
        end
    end

    // Interrupt level from enabled mismatch or event bits
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|(hdr_stat_q & hdr_ien_q)) || (|(evt_stat_q & evt_ien_q));
        end
    end
    assign irq_out = irq_q;

    // Checks
    sequence seq_access_wait;
        psel_in && penable_in && !pready_q;
    endsequence
    sequence seq_plain_size_pkt;
        sv_inc && !snap;
    endsequence
    sequence seq_snap_then_done;
        snap ##1 upd_done_q;
    endsequence
    sequence seq_addr_status_read;
        rd_done && idx == `IDX_HDR_STAT && prdata_q[`HDR_ADDR_BIT] && !hdr_miss[`HDR_ADDR_BIT];
    endsequence

    chk_bus_wait_one: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        seq_access_wait |=> pready_q ##1 !pready_q)
        else $error("Bus answer not after one wait state");
    chk_size_count_inc: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        seq_plain_size_pkt |=> sv_live_q == $past(sv_live_q) + 24'h000001)
        else $error("Size violation count did not step");
    chk_size_bytes_abort: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        seq_plain_size_pkt |=> abt_live_q == $past(abt_live_q) + {16'h0000, $past(pkt_in.len)}
            && good_live_q == $past(good_live_q))
        else $error("Size violation bytes misrouted");
    chk_good_bytes_add: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        pkt_in.valid && !pkt_in.abort && !pkt_in.size_viol && !snap
            |=> good_live_q == $past(good_live_q) + {16'h0000, $past(pkt_in.len)})
        else $error("Good byte count did not add length");
    chk_snap_copy: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        snap |=> good_shadow_q == $past(good_live_q) && sv_shadow_q == $past(sv_live_q)
            && abt_live_q == $past(abt_add))
        else $error("Snapshot did not copy and restart");
    chk_done_cycle: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        $rose(upd_req_q) |-> seq_snap_then_done ##1 (upd_done_q || !$past(upd_req_q)))
        else $error("Update done not set after snapshot");
    chk_done_clear: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !upd_req_q |=> !upd_done_q)
        else $error("Update done not cleared");
    chk_hdr_latch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        hdr_in.valid && hdr_in.addr != exp_addr_q |=> hdr_stat_q[`HDR_ADDR_BIT])
        else $error("Address mismatch not latched");
    chk_hdr_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        hdr_stat_q[`HDR_SAPI_H_BIT] && !(rd_done && idx == `IDX_HDR_STAT) |=> hdr_stat_q[`HDR_SAPI_H_BIT])
        else $error("Mismatch bit lost before read");
    chk_irq_follow: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        |(hdr_stat_q & hdr_ien_q) |=> irq_q)
        else $error("Interrupt not raised for enabled mismatch");
    chk_wm_scale: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        ##1 wm_bytes_q == {$past(wm_q), 16'h0000})
        else $error("Watermark position wrong");

    // Status clearing, aborted byte add, remaining latches, counter restart, interrupt gating and done hold
    chk_hdr_read_clear: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        seq_addr_status_read |=> !hdr_stat_q[`HDR_ADDR_BIT])
        else $error("Address mismatch bit not cleared by read");
    chk_abort_bytes_add: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        pkt_in.valid && pkt_in.abort && !snap
            |=> abt_live_q == $past(abt_live_q) + {16'h0000, $past(pkt_in.len)})
        else $error("Aborted byte count did not add length");
    chk_irq_enable_gate: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        !(|(hdr_stat_q & hdr_ien_q)) && !(|(evt_stat_q & evt_ien_q)) |=> !irq_q)
        else $error("Interrupt raised with no enabled cause");
    chk_sapi_high_latch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        hdr_in.valid && hdr_in.sapi_h != exp_sapi_h_q |=> hdr_stat_q[`HDR_SAPI_H_BIT])
        else $error("High SAPI mismatch not latched");
    chk_sapi_low_latch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        hdr_in.valid && hdr_in.sapi_l != exp_sapi_l_q |=> hdr_stat_q[`HDR_SAPI_L_BIT])
        else $error("Low SAPI mismatch not latched");
    chk_ctrl_field_latch: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        hdr_in.valid && hdr_in.ctrl != exp_ctrl_q |=> hdr_stat_q[`HDR_CTRL_BIT])
        else $error("Control mismatch not latched");
    chk_snap_restart: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        snap |=> sv_live_q == {23'h000000, $past(sv_inc)} && good_live_q == $past(good_add))
        else $error("Live counters not restarted at snapshot");
    chk_done_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
        upd_done_q && upd_req_q |=> upd_done_q)
        else $error("Update done dropped while update bit set");

endmodule : rx_packet_perf_monitor
`default_nettype wire

// ==== verilog/rx_perf_defines.svh ====
// Register indices, field positions and reset values of the receive monitor
`ifndef RX_PERF_DEFINES_SVH
`define RX_PERF_DEFINES_SVH
// Register indices; byte address on the bus is four times the index
`define IDX_SV_CNT0 10'h114
`define IDX_SV_CNT1 10'h115
`define IDX_SV_CNT2 10'h116
`define IDX_GOOD_CNT0 10'h118
`define IDX_GOOD_CNT1 10'h119
`define IDX_GOOD_CNT2 10'h11a
`define IDX_GOOD_CNT3 10'h11b
`define IDX_ABT_CNT0 10'h11c
`define IDX_ABT_CNT1 10'h11d
`define IDX_ABT_CNT2 10'h11e
`define IDX_ABT_CNT3 10'h11f
`define IDX_UPD_CTRL 10'h120
`define IDX_UPD_DONE 10'h121
`define IDX_HDR_STAT 10'h122
`define IDX_HDR_IEN 10'h123
`define IDX_TXQ_LOW_WM 10'h124
`define IDX_EXP_SAPI_H 10'h128
`define IDX_EXP_SAPI_L 10'h129
`define IDX_EXP_CTRL 10'h12a
`define IDX_EXP_ADDR 10'h12b
`define IDX_EVT_STAT 10'h12c
`define IDX_EVT_CLR 10'h12d
`define IDX_EVT_IEN 10'h12e
// Field positions
`define UPD_REQ_BIT 0
`define HDR_SAPI_H_BIT 3
`define HDR_SAPI_L_BIT 2
`define HDR_CTRL_BIT 1
`define HDR_ADDR_BIT 0
`define EVT_SNAP_BIT 0
`define EVT_HDR_BIT 1
// Reset values
`define RST_BYTE 8'h00
`define RST_EXP_BYTE 8'h00
// Watermark scaling: 32 packets of 2048 bytes per step
`define WM_PKTS_PER_STEP 32
`define WM_BYTES_PER_PKT 2048
`define WM_SHIFT 16
`endif

// ==== verilog/rx_perf_pkg.sv ====
// Types shared by the receive monitor
`default_nettype none
package rx_perf_pkg;
    // Packet-end report from the receive packet processor
    typedef struct packed {
        logic valid;
        logic abort;
        logic size_viol;
        logic [15:0] len;
    } rx_pkt_t;
    // Received X.86 header octets
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] ctrl;
        logic [7:0] sapi_h;
        logic [7:0] sapi_l;
    } rx_hdr_t;
    // Bus slave phase, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_RESP = 2'b10
    } bus_state_t;
endpackage : rx_perf_pkg
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the receive performance monitor register block
`include "rx_perf_defines.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
    logic pready_out, pslverr_out, irq_out;
    logic [11:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rv;
    logic [23:0] txq_low_wm_bytes_out;
    rx_perf_pkg::rx_pkt_t pkt_in;
    rx_perf_pkg::rx_hdr_t hdr_in;
    int fails, comparisons;
    logic ev;
    logic [3:0] m;
    logic [7:0] f [4];
    logic [7:0] g [4];
    logic [9:0] rst_idx [13] = '{`IDX_SV_CNT0, `IDX_SV_CNT1, `IDX_SV_CNT2, `IDX_GOOD_CNT0, `IDX_GOOD_CNT1,
        `IDX_GOOD_CNT2, `IDX_GOOD_CNT3, `IDX_ABT_CNT0, `IDX_ABT_CNT1, `IDX_ABT_CNT2, `IDX_ABT_CNT3,
        `IDX_UPD_CTRL, `IDX_UPD_DONE};
    logic [9:0] exp_idx [4] = '{`IDX_EXP_ADDR, `IDX_EXP_CTRL, `IDX_EXP_SAPI_L, `IDX_EXP_SAPI_H};

    rx_packet_perf_monitor uut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .pkt_in(pkt_in),
        .hdr_in(hdr_in), .txq_low_wm_bytes_out(txq_low_wm_bytes_out), .irq_out(irq_out));

    // Free-running system clock
    always #2 core_clk_in = ~core_clk_in;

    // Prints the counts and the verdict, then stops
    task automatic end_of_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // Compares a seen value with the expected one
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check

    // One APB transfer; entered just after a rising edge, leaves one idle cycle
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel_in <= 1'b1;
        penable_in <= 1'b0;
        pwrite_in <= wr;
        paddr_in <= {idx, 2'b00};
        pwdata_in <= wd;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            $display("MISMATCH t=%0t no ready answer", $time);
            end_of_test();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge core_clk_in);
    endtask : apb

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask : wr

    // Reads one register and compares it
    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
        logic [31:0] d;
        logic e;
        apb(1'b0, idx, 32'h0, d, e);
        check(d, exp, msg);
    endtask : rd_chk

    // Assembles a counter from byte registers, lowest index is the low byte
    task automatic rd_cnt(input logic [9:0] base, input int nb, output logic [31:0] val);
        logic [31:0] d;
        logic e;
        val = 32'h0;
        for (int i = 0; i < nb; i++) begin
            apb(1'b0, base + 10'(i), 32'h0, d, e);
            val[8*i +: 8] = d[7:0];
        end
    endtask : rd_cnt

    // Reports one packet end
    task automatic pkt(input logic ab, input logic sv, input logic [15:0] len);
        pkt_in <= '{1'b1, ab, sv, len};
        @(posedge core_clk_in);
        pkt_in <= '0;
        @(posedge core_clk_in);
    endtask : pkt

    // Reports one header: address, control, low sapi, high sapi
    task automatic hdr(input logic [7:0] h [4]);
        hdr_in <= '{1'b1, h[0], h[1], h[3], h[2]};
        @(posedge core_clk_in);
        hdr_in <= '0;
        @(posedge core_clk_in);
    endtask : hdr

    // Main sequence
    initial begin
        core_clk_in = 1'b0;
        sys_rst_in = 1'b1;
        {psel_in, penable_in, pwrite_in} = 3'h0;
        paddr_in = 12'h000;
        pwdata_in = 32'h0;
        pkt_in = '0;
        hdr_in = '0;
        fails = 0;
        comparisons = 0;
        f = '{8'h03, 8'h13, 8'h5c, 8'hc5};
        repeat (5) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        foreach (rst_idx[i]) rd_chk(rst_idx[i], 32'h0, "reset value");
        rd_chk(`IDX_HDR_IEN, 32'h0, "irq enable reset");
        rd_chk(`IDX_TXQ_LOW_WM, 32'h0, "watermark reset");
        $display("test reset values done");
        wr(`IDX_TXQ_LOW_WM, 32'hffff_ffa5);
        rd_chk(`IDX_TXQ_LOW_WM, 32'h0000_00a5, "watermark readback");
        check({8'h00, txq_low_wm_bytes_out}, 32'ha5 * 32 * 2048, "watermark bytes");
        $display("test watermark done");
        pkt(1'b0, 1'b0, 16'h1234);
        pkt(1'b1, 1'b0, 16'h0050);
        pkt(1'b0, 1'b1, 16'h001e);
        pkt(1'b1, 1'b1, 16'h0007);
        pkt(1'b0, 1'b0, 16'h0100);
        rd_cnt(`IDX_GOOD_CNT0, 4, rv);
        check(rv, 32'h0, "copy before snapshot");
        wr(`IDX_UPD_CTRL, 32'h0000_00ff);
        rd_chk(`IDX_UPD_CTRL, 32'h0000_0001, "update control bits");
        rd_chk(`IDX_UPD_DONE, 32'h0000_0001, "done after snapshot");
        rd_cnt(`IDX_SV_CNT0, 3, rv);
        check(rv, 32'h2, "size violation count");
        rd_cnt(`IDX_GOOD_CNT0, 4, rv);
        check(rv, 32'h1334, "good byte count");
        rd_cnt(`IDX_ABT_CNT0, 4, rv);
        check(rv, 32'h75, "aborted byte count");
        wr(`IDX_GOOD_CNT0, 32'h0000_00ff);
        rd_chk(`IDX_GOOD_CNT0, 32'h0000_0034, "read-only byte kept");
        wr(`IDX_UPD_CTRL, 32'h0);
        rd_chk(`IDX_UPD_DONE, 32'h0, "done cleared by zero");
        pkt(1'b0, 1'b0, 16'h0005);
        wr(`IDX_UPD_CTRL, 32'h1);
        rd_cnt(`IDX_GOOD_CNT0, 4, rv);
        check(rv, 32'h5, "good count restarted");
        rd_cnt(`IDX_SV_CNT0, 3, rv);
        check(rv, 32'h0, "size count restarted");
        rd_cnt(`IDX_ABT_CNT0, 4, rv);
        check(rv, 32'h0, "aborted count restarted");
        wr(`IDX_UPD_CTRL, 32'h0);
        $display("test counters done");
        apb(1'b0, 10'h117, 32'h0, rv, ev);
        check({31'h0, ev}, 32'h1, "unmapped error");
        check(rv, 32'h0, "unmapped read data");
        $display("test unmapped done");
        foreach (f[i]) wr(exp_idx[i], {24'h0, f[i]});
        hdr(f);
        rd_chk(`IDX_HDR_STAT, 32'h0, "matching header");
        for (int i = 0; i < 4; i++) begin
            m = 4'h1 << i;
            g = f;
            g[i] = ~f[i];
            wr(`IDX_HDR_IEN, {28'h0, ~m});
            hdr(g);
            repeat (3) @(posedge core_clk_in);
            check({31'h0, irq_out}, 32'h0, "masked mismatch");
            wr(`IDX_HDR_IEN, {28'h0, m});
            repeat (2) @(posedge core_clk_in);
            check({31'h0, irq_out}, 32'h1, "enabled mismatch");
            rd_chk(`IDX_HDR_STAT, {28'h0, m}, "mismatch latched");
            repeat (2) @(posedge core_clk_in);
            check({31'h0, irq_out}, 32'h0, "irq after read");
            rd_chk(`IDX_HDR_STAT, 32'h0, "cleared on read");
        end
        $display("test header check done");
        rd_chk(`IDX_EVT_STAT, 32'h3, "event status");
        wr(`IDX_EVT_IEN, 32'h1);
        @(posedge core_clk_in);
        check({31'h0, irq_out}, 32'h1, "event irq");
        wr(`IDX_EVT_CLR, 32'h1);
        rd_chk(`IDX_EVT_STAT, 32'h2, "event cleared");
        check({31'h0, irq_out}, 32'h0, "event irq cleared");
        $display("test events done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
